/* File: design/oad_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oad_consts.svh"

module oad_decode #(
   parameter int SLOTS = `OAD_SLOTS,
   parameter int IW    = $clog2(SLOTS)
) (
   input  wire logic                  core_clk_i,      // Core clock
   input  wire logic                  rst_i,           // Async reset
   input  wire logic                  start_i,         // Begin instruction
   input  wire oad_pkg::oad_mode_t    mode_i,          // Addressing class
   input  wire logic [7:0]            index_postbyte_i, // Index postbyte
   input  wire logic [7:0]            ext_hi_i,        // First ext byte
   input  wire logic [7:0]            ext_lo_i,        // Last ext byte
   input  wire logic [15:0]           reg_x_i,         // Index X
   input  wire logic [15:0]           reg_y_i,         // Index Y
   input  wire logic [15:0]           stack_pointer_i, // Stack pointer
   input  wire logic [15:0]           program_counter_i, // Next byte addr
   input  wire logic [7:0]            acc_a_i,         // Accumulator A
   input  wire logic [7:0]            acc_b_i,         // Accumulator B
   input  wire logic [15:0]           fetch_addr_i,    // Instr. start
   input  wire logic                  page2_i,         // Prefix present
   input  wire logic [2:0]            obj_bytes_i,     // Object code bytes
   input  wire logic                  cond_i,          // t/x condition
   input  wire logic                  taken_i,         // Branch taken
   input  wire logic [SLOTS*4-1:0]    seq_i,           // Access codes
   input  wire logic [IW:0]           seq_len_i,       // Code count
   input  wire logic [SLOTS-1:0]      irq_mark_i,      // Honour points
   input  wire logic [IW-1:0]         loop_beg_i,      // Loop first slot
   input  wire logic [IW-1:0]         loop_end_i,      // Loop last slot
   input  wire logic [7:0]            loop_cnt_i,      // Extra passes
   input  wire logic [15:0]           vector_addr_i,   // Vector location
   input  wire logic [7:0]            trap_num_i,      // Trap number
   input  wire logic [15:0]           bus_rdata_i,     // Read data
   output logic                       busy_o,          // Sequence active
   output logic                       bus_req_o,       // Access made
   output oad_pkg::oad_kind_t         bus_kind_o,      // Cycle class
   output logic                       bus_wide_o,      // 16-bit access
   output logic                       bus_write_o,     // Write access
   output logic [15:0]                bus_addr_o,      // Access address
   output logic [15:0]                ea_o,            // Effective addr
   output logic                       ea_valid_o,      // ea_o final
   output logic                       wb_en_o,         // Index update
   output logic [1:0]                 wb_sel_o,        // 0 X,1 Y,2 SP
   output logic [15:0]                wb_val_o,        // New index value
   output logic                       irq_ok_o,        // Honour point
   output logic                       trap_ok_o        // Valid user trap
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Base register chosen by a two-bit field
   function automatic logic [15:0] oad_base(input logic [1:0] rr,
      input logic [15:0] x, input logic [15:0] y,
      input logic [15:0] sp, input logic [15:0] pc);
      unique case (rr)
         2'h0: oad_base = x;
         2'h1: oad_base = y;
         2'h2: oad_base = sp;
         default: oad_base = pc;
      endcase
   endfunction : oad_base

   // Nine-bit signed offset widened to sixteen bits
   function automatic logic [15:0] oad_sx9(input logic s,
      input logic [7:0] lo);
      oad_sx9 = {{8{s}}, lo};
   endfunction : oad_sx9

   ////////////////////////////////////////////////////////////////////
   // Effective address and index write-back

   oad_pkg::oad_state_t state;
   logic        start_ok;
   logic [15:0] base_a;
   logic [15:0] base_b;
   logic [15:0] delta;
   logic [15:0] acc_d;
   logic [15:0] next_ea;
   logic        next_ind;
   logic        next_wb;
   logic [15:0] next_wbv;

   assign start_ok = start_i && (state == oad_pkg::ST_IDLE);
   assign acc_d    = {acc_a_i, acc_b_i};
   assign base_a   = oad_base(index_postbyte_i[7:6], reg_x_i, reg_y_i,
                              stack_pointer_i, program_counter_i);
   assign base_b   = oad_base(index_postbyte_i[4:3], reg_x_i, reg_y_i,
                              stack_pointer_i, program_counter_i);
   // Step of 1..8 up, or 1..8 down as a sign-extended nibble
   assign delta = index_postbyte_i[`OAD_PB_NEG] ?
                  {12'hFFF, index_postbyte_i[3:0]} :
                  {13'h0000, index_postbyte_i[2:0]} + 16'h0001;

   // All sums are 16 bits wide so they wrap without any fault
   always_comb begin
      next_ea  = 16'h0000;
      next_ind = 1'b0;
      next_wb  = 1'b0;
      next_wbv = base_a + delta;
      unique case (mode_i)
         oad_pkg::M_DIRECT: next_ea = {8'h00, ext_lo_i};
         oad_pkg::M_FULL:   next_ea = {ext_hi_i, ext_lo_i};
         oad_pkg::M_REL8:
            next_ea = program_counter_i + {{8{ext_lo_i[7]}}, ext_lo_i};
         oad_pkg::M_REL9:
            next_ea = program_counter_i +
                      oad_sx9(index_postbyte_i[`OAD_PB_SIGN], ext_lo_i);
         oad_pkg::M_REL16:
            next_ea = program_counter_i + {ext_hi_i, ext_lo_i};
         oad_pkg::M_INDEXED: begin
            if (!index_postbyte_i[`OAD_PB_LONG]) begin
               next_ea = base_a + {{11{index_postbyte_i[4]}},
                                   index_postbyte_i[4:0]};
            end else if (index_postbyte_i[7:6] != `OAD_RR_EXT) begin
               next_wb = 1'b1;
               next_ea = index_postbyte_i[`OAD_PB_POST] ? base_a
                                                         : next_wbv;
            end else begin
               unique case (index_postbyte_i[2:0])
                  3'h0, 3'h1: next_ea = base_b + oad_sx9(
                     index_postbyte_i[0], ext_lo_i);
                  3'h2: next_ea = base_b + {ext_hi_i, ext_lo_i};
                  3'h3: begin
                     next_ea  = base_b + {ext_hi_i, ext_lo_i};
                     next_ind = 1'b1;
                  end
                  3'h4: next_ea = base_b + {8'h00, acc_a_i};
                  3'h5: next_ea = base_b + {8'h00, acc_b_i};
                  3'h6: next_ea = base_b + acc_d;
                  default: begin
                     next_ea  = base_b + acc_d;
                     next_ind = 1'b1;
                  end
               endcase
            end
         end
         default: next_ea = 16'h0000;
      endcase
   end

   // User trap numbers: two windows only, gap between them refused
   assign trap_ok_o = (trap_num_i >= `OAD_TRAP_LO1) &&
                      ((trap_num_i <= `OAD_TRAP_HI1) ||
                       (trap_num_i >= `OAD_TRAP_LO2));

   ////////////////////////////////////////////////////////////////////
   // Cycle sequence

   logic [SLOTS*4-1:0] seq_q;
   logic [IW:0]        len_q;
   logic [SLOTS-1:0]   mark_q;
   logic [IW-1:0]      idx;
   logic [IW-1:0]      lbeg_q;
   logic [IW-1:0]      lend_q;
   logic [7:0]         rem;
   logic [15:0]        fptr;
   logic [15:0]        sp_q;
   logic [15:0]        vec_q;
   logic               opt_q;
   logic               cond_q;
   logic               ind_q;
   logic [SLOTS*4-1:0] next_seq;
   logic [IW:0]        next_len;
   logic               next_opt;
   logic [15:0]        eff_start;
   logic [2:0]         eff_bytes;
   logic               last;
   logic               wrap;

   // The prefix is its own one-byte instruction, so the main body
   // starts one byte later and has one byte fewer
   assign eff_start = fetch_addr_i + {15'h0000, page2_i};
   assign eff_bytes = obj_bytes_i - {2'b00, page2_i};
   assign next_opt  = eff_start[0] && eff_bytes[0];

   // Branches build their own fetch pattern; others use seq_i
   always_comb begin
      next_seq = '0;
      next_len = seq_len_i;
      unique case (mode_i)
         oad_pkg::M_REL8: begin
            next_seq[11:0] = {oad_pkg::CY_P, oad_pkg::CY_P, oad_pkg::CY_P};
            next_len = taken_i ? (IW+1)'(3) : (IW+1)'(1);
         end
         oad_pkg::M_REL16: begin
            next_seq[15:0] = taken_i ?
               {oad_pkg::CY_P, oad_pkg::CY_P, oad_pkg::CY_P, oad_pkg::CY_O} :
               {oad_pkg::CY_F, oad_pkg::CY_O, oad_pkg::CY_P, oad_pkg::CY_O};
            next_len = taken_i ? (IW+1)'(4) : (IW+1)'(3);
         end
         default: next_seq = seq_i;
      endcase
   end

   assign wrap = (idx == lend_q) && (rem != 8'h00);
   assign last = !wrap && (({1'b0, idx} + (IW+1)'(1)) >= len_q);

   // Sequencer state; a loop replays its slots, marks included
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state  <= oad_pkg::ST_IDLE;
         idx    <= '0;
         rem    <= 8'h00;
         seq_q  <= '0;
         len_q  <= '0;
         mark_q <= '0;
         lbeg_q <= '0;
         lend_q <= '0;
         sp_q   <= 16'h0000;
         vec_q  <= 16'h0000;
         opt_q  <= 1'b0;
         cond_q <= 1'b0;
      end else if (start_ok) begin
         state  <= (next_len != '0) ? oad_pkg::ST_RUN : oad_pkg::ST_IDLE;
         idx    <= '0;
         rem    <= loop_cnt_i;
         seq_q  <= next_seq;
         len_q  <= next_len;
         mark_q <= (mode_i == oad_pkg::M_REL8 ||
                    mode_i == oad_pkg::M_REL16) ? '0 : irq_mark_i;
         lbeg_q <= loop_beg_i;
         lend_q <= loop_end_i;
         sp_q   <= stack_pointer_i;
         vec_q  <= vector_addr_i;
         opt_q  <= next_opt;
         cond_q <= cond_i;
      end else if (state == oad_pkg::ST_RUN) begin
         if (wrap) begin
            idx <= lbeg_q;
            rem <= rem - 8'h01;
         end else begin
            idx <= idx + IW'(1);
         end
         if (last) begin
            state <= oad_pkg::ST_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Resolve the current code into one bus cycle

   oad_pkg::oad_cyc_t  code;
   oad_pkg::oad_kind_t next_kind;
   logic               next_wide;
   logic [15:0]        next_addr;
   logic               next_fadv;

   assign code = oad_pkg::oad_cyc_t'(seq_q[idx*4 +: 4]);

   // Upper-case codes move a word, lower-case a byte, one cycle each
   always_comb begin
      next_kind = oad_pkg::K_FREE;
      next_wide = 1'b0;
      next_addr = 16'h0000;
      next_fadv = 1'b0;
      unique case (code)
         oad_pkg::CY_P, oad_pkg::CY_O: begin
            if (code == oad_pkg::CY_P || opt_q) begin
               next_kind = oad_pkg::K_PROG;
               next_wide = 1'b1;
               next_addr = {fptr[15:1], 1'b0};
               next_fadv = 1'b1;
            end
         end
         oad_pkg::CY_BR, oad_pkg::CY_WR: begin
            next_kind = oad_pkg::K_READ;
            next_wide = (code == oad_pkg::CY_WR);
            next_addr = ea_o;
         end
         oad_pkg::CY_BW, oad_pkg::CY_WW: begin
            next_kind = oad_pkg::K_WRITE;
            next_wide = (code == oad_pkg::CY_WW);
            next_addr = ea_o;
         end
         oad_pkg::CY_BS, oad_pkg::CY_WS: begin
            next_kind = oad_pkg::K_SWRITE;
            next_wide = (code == oad_pkg::CY_WS);
            next_addr = sp_q;
         end
         oad_pkg::CY_BU, oad_pkg::CY_WU: begin
            next_kind = oad_pkg::K_SREAD;
            next_wide = (code == oad_pkg::CY_WU);
            next_addr = sp_q;
         end
         oad_pkg::CY_V: begin
            next_kind = oad_pkg::K_VECT;
            next_wide = 1'b1;
            next_addr = {vec_q[15:1], 1'b0};
         end
         oad_pkg::CY_T, oad_pkg::CY_X: begin
            if (cond_q) begin
               next_kind = (code == oad_pkg::CY_T) ? oad_pkg::K_READ
                                                    : oad_pkg::K_WRITE;
               next_addr = ea_o;
            end
         end
         oad_pkg::CY_I: begin
            next_kind = oad_pkg::K_PTR;
            next_wide = 1'b1;
            next_addr = ea_o;
         end
         default: next_kind = oad_pkg::K_FREE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Registered bus outputs

   // Outputs lag the slot by one edge so the bus sees flop outputs
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus_kind_o  <= oad_pkg::K_FREE;
         bus_wide_o  <= 1'b0;
         bus_addr_o  <= 16'h0000;
         irq_ok_o    <= 1'b0;
      end else if (state == oad_pkg::ST_RUN) begin
         bus_kind_o  <= next_kind;
         bus_wide_o  <= next_wide;
         bus_addr_o  <= next_addr;
         irq_ok_o    <= mark_q[idx];
      end else begin
         bus_kind_o  <= oad_pkg::K_FREE;
         bus_wide_o  <= 1'b0;
         bus_addr_o  <= 16'h0000;
         irq_ok_o    <= 1'b0;
      end
   end

   assign bus_req_o   = (bus_kind_o != oad_pkg::K_FREE);
   assign bus_write_o = (bus_kind_o == oad_pkg::K_WRITE) ||
                        (bus_kind_o == oad_pkg::K_SWRITE);
   assign busy_o      = (state == oad_pkg::ST_RUN);

   // Fetch pointer; a taken branch refetches from its target
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fptr <= 16'h0000;
      end else if (start_ok) begin
         fptr <= ((mode_i == oad_pkg::M_REL8 ||
                   mode_i == oad_pkg::M_REL16) && taken_i) ?
                 next_ea : eff_start;
      end else if (state == oad_pkg::ST_RUN && next_fadv) begin
         fptr <= {fptr[15:1], 1'b0} + 16'h0002;
      end
   end

   // Effective address; an indirect form swaps in the pointer read
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ea_o       <= 16'h0000;
         ea_valid_o <= 1'b0;
         ind_q      <= 1'b0;
         wb_en_o    <= 1'b0;
         wb_sel_o   <= 2'h0;
         wb_val_o   <= 16'h0000;
      end else begin
         wb_en_o <= start_ok && next_wb;
         if (start_ok) begin
            ea_o       <= next_ea;
            ea_valid_o <= !next_ind && (mode_i != oad_pkg::M_NONE);
            ind_q      <= next_ind;
            wb_sel_o   <= index_postbyte_i[7:6];
            wb_val_o   <= next_wbv;
         end else if (ind_q && bus_kind_o == oad_pkg::K_PTR) begin
            ea_o       <= bus_rdata_i;
            ea_valid_o <= 1'b1;
            ind_q      <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_fetch3;
      (bus_kind_o == oad_pkg::K_PROG) [*3] ##1 !busy_o;
   endsequence
   sequence s_fetch1;
      (bus_kind_o == oad_pkg::K_PROG) ##1 (bus_kind_o == oad_pkg::K_FREE);
   endsequence

   property p_direct;
      start_ok && mode_i == oad_pkg::M_DIRECT |=>
         ea_o == {8'h00, $past(ext_lo_i)} && ea_valid_o;
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct address high byte not zero");
   property p_full;
      start_ok && mode_i == oad_pkg::M_FULL |=>
         ea_o[15:8] == $past(ext_hi_i) && ea_o[7:0] == $past(ext_lo_i);
   endproperty
   a_full: assert property (p_full)
      else $error("full address byte order wrong");
   property p_rel8;
      start_ok && mode_i == oad_pkg::M_REL8 |=>
         ea_o - $past(program_counter_i) ==
         {{8{$past(ext_lo_i[7])}}, $past(ext_lo_i)};
   endproperty
   a_rel8: assert property (p_rel8)
      else $error("short branch target wrong");
   property p_auto;
      start_ok && mode_i == oad_pkg::M_INDEXED &&
      index_postbyte_i[5] && index_postbyte_i[7:6] != 2'h3 |=>
         wb_en_o && ((ea_o == wb_val_o) == !$past(index_postbyte_i[4]))
         ##1 !wb_en_o;
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto-modify write-back wrong");
   // A free slot, or a conditional slot whose condition is false,
   // must leave the bus idle in the cycle it is shown
   property p_free;
      busy_o && (code == oad_pkg::CY_F ||
                 (code inside {oad_pkg::CY_T, oad_pkg::CY_X} && !cond_q))
      |=> !bus_req_o && !bus_write_o && !bus_wide_o;
   endproperty
   a_free: assert property (p_free)
      else $error("bus access in free cycle");
   property p_pfetch;
      bus_kind_o == oad_pkg::K_PROG |-> bus_wide_o && !bus_addr_o[0];
   endproperty
   a_pfetch: assert property (p_pfetch)
      else $error("program fetch not aligned word");
   property p_vect;
      bus_kind_o == oad_pkg::K_VECT |-> bus_wide_o && !bus_addr_o[0];
   endproperty
   a_vect: assert property (p_vect)
      else $error("vector fetch not aligned word");
   property p_trap;
      trap_ok_o |-> trap_num_i[7:4] != 4'h0 && trap_num_i[7:4] != 4'h1 &&
                    trap_num_i[7:4] != 4'h2 &&
                    !(trap_num_i[7:4] == 4'h3 && trap_num_i[3:0] > 4'h9);
   endproperty
   a_trap: assert property (p_trap)
      else $error("invalid trap number accepted");
   property p_br_taken;
      start_ok && mode_i == oad_pkg::M_REL8 && taken_i |=> ##1 s_fetch3;
   endproperty
   a_br_taken: assert property (p_br_taken)
      else $error("taken short branch not three fetches");
   property p_br_not;
      start_ok && mode_i == oad_pkg::M_REL8 && !taken_i |=> ##1 s_fetch1;
   endproperty
   a_br_not: assert property (p_br_not)
      else $error("untaken short branch not one fetch");

endmodule : oad_decode
`default_nettype wire

/* File: pkg/oad_consts.svh */
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH

// Sequence slots and field positions of the index postbyte
`define OAD_SLOTS       8
`define OAD_PB_LONG     5
`define OAD_PB_SIGN     4
`define OAD_PB_POST     4
`define OAD_PB_NEG      3
`define OAD_RR_EXT      2'h3
`define OAD_TRAP_LO1    8'h30
`define OAD_TRAP_HI1    8'h39
`define OAD_TRAP_LO2    8'h40
`endif

/* File: pkg/oad_pkg.sv */
`default_nettype none
package oad_pkg;
   // Access codes of one instruction cycle, as the sequence lists them
   typedef enum logic [3:0] {
      CY_F = 4'h0, CY_P = 4'h1, CY_O = 4'h2, CY_BR = 4'h3,
      CY_WR = 4'h4, CY_BW = 4'h5, CY_WW = 4'h6, CY_BS = 4'h7,
      CY_WS = 4'h8, CY_BU = 4'h9, CY_WU = 4'hA, CY_V = 4'hB,
      CY_T = 4'hC, CY_X = 4'hD, CY_I = 4'hE
   } oad_cyc_t;
   // Operand addressing class of the instruction
   typedef enum logic [2:0] {
      M_NONE = 3'h0, M_DIRECT = 3'h1, M_FULL = 3'h2, M_INDEXED = 3'h3,
      M_REL8 = 3'h4, M_REL9 = 3'h5, M_REL16 = 3'h6
   } oad_mode_t;
   // Bus cycle class shown to the memory system
   typedef enum logic [2:0] {
      K_FREE = 3'h0, K_PROG = 3'h1, K_READ = 3'h2, K_WRITE = 3'h3,
      K_SREAD = 3'h4, K_SWRITE = 3'h5, K_VECT = 3'h6, K_PTR = 3'h7
   } oad_kind_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} oad_state_t;
endpackage : oad_pkg
`default_nettype wire

/* File: bench/oad_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module oad_mem_model (
   input  wire logic               core_clk_i, // Core clock
   input  wire logic               rst_i,      // Async reset
   input  wire oad_pkg::oad_kind_t kind_i,     // Cycle class
   input  wire logic [15:0]        addr_i,     // Access address
   output logic [15:0]             rdata_o     // Pointer word
);
   logic [15:0] last;
   // Pointer words are a scramble of the address, so the bench can predict
   always_comb begin
      if (kind_i == oad_pkg::K_PTR)
         rdata_o = {addr_i[7:0], addr_i[15:8]} ^ 16'h5A3C;
      else
         rdata_o = ~last;
   end
   // Released data toggles, so a stale word never passes for a pointer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i)
         last <= 16'h0000;
      else
         last <= rdata_o;
   end
endmodule : oad_mem_model
`default_nettype wire

/* File: bench/oad_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module oad_decode_test;
   logic core_clk_i = 0, rst_i = 1, start_i = 0, page2_i = 0, cond_i = 0;
   logic taken_i = 0, busy_o, bus_req_o, bus_wide_o, bus_write_o;
   logic ea_valid_o, wb_en_o, irq_ok_o, trap_ok_o;
   oad_pkg::oad_mode_t mode_i = oad_pkg::M_NONE;
   oad_pkg::oad_kind_t bus_kind_o;
   logic [7:0] index_postbyte_i = 0, ext_hi_i = 0, ext_lo_i = 0;
   logic [7:0] acc_a_i = 8'h70, acc_b_i = 8'h05, loop_cnt_i = 0;
   logic [7:0] trap_num_i = 0, irq_mark_i = 0;
   logic [15:0] reg_x_i = 16'h0008, reg_y_i = 16'h4000;
   logic [15:0] stack_pointer_i = 16'h0100, program_counter_i = 16'h2001;
   logic [15:0] fetch_addr_i = 0, vector_addr_i = 0;
   logic [15:0] bus_rdata_i, bus_addr_o, ea_o, wb_val_o;
   logic [31:0] seq_i = 0;
   logic [3:0]  seq_len_i = 0;
   logic [2:0]  obj_bytes_i = 0, loop_beg_i = 0, loop_end_i = 0;
   logic [1:0]  wb_sel_o;
   int          fails = 0, samples_checked = 0;
   oad_decode dut_u (.*);
   oad_mem_model mem_u (.core_clk_i, .rst_i, .kind_i(bus_kind_o),
      .addr_i(bus_addr_o), .rdata_o(bus_rdata_i));
   always #4 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("%0d checks, %0d wrong", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task tick;
      @(posedge core_clk_i);
      #1;
   endtask : tick
   // Bounded wait, so a stuck sequence ends the run instead of hanging
   task idle;
      int i;
      for (i = 0; i < 40 && busy_o !== 1'b0; i++) tick;
      if (i == 40) begin
         fails++;
         give_verdict;
      end
   endtask : idle
   // Start pulse lasts one edge; returns in the cycle after acceptance
   task go(input oad_pkg::oad_mode_t m, input logic [7:0] p, h, l);
      @(posedge core_clk_i);
      mode_i <= m;
      index_postbyte_i <= p;
      ext_hi_i <= h;
      ext_lo_i <= l;
      start_i <= 1'b1;
      @(posedge core_clk_i);
      start_i <= 1'b0;
      #1;
   endtask : go
   task ix(input oad_pkg::oad_mode_t m, input logic [7:0] p, h, l,
           input logic [15:0] e);
      go(m, p, h, l);
      `CHK("ea", e, ea_o)
      `CHK("ea_valid", 1'b1, ea_valid_o)
      idle;
   endtask : ix
   task aut(input logic [7:0] p, input logic [15:0] e, v,
            input logic [1:0] s);
      go(oad_pkg::M_INDEXED, p, 8'h00, 8'h00);
      `CHK("ea", e, ea_o)
      `CHK("wb_en", 1'b1, wb_en_o)
      `CHK("wb_sel", s, wb_sel_o)
      `CHK("wb_val", v, wb_val_o)
      idle;
   endtask : aut
   task t_modes;
      ix(oad_pkg::M_DIRECT, 8'h00, 8'hA5, 8'hA5, 16'h00A5);
      ix(oad_pkg::M_INDEXED, 8'h10, 8'h00, 8'h00, 16'hFFF8);
      ix(oad_pkg::M_INDEXED, 8'hCF, 8'h00, 8'h00, 16'h2010);
      ix(oad_pkg::M_INDEXED, 8'hE1, 8'h00, 8'h00, 16'hFF08);
      ix(oad_pkg::M_INDEXED, 8'hE8, 8'hFF, 8'hFF, 16'h40FF);
      ix(oad_pkg::M_INDEXED, 8'hFA, 8'h80, 8'h00, 16'hA001);
      ix(oad_pkg::M_INDEXED, 8'hE4, 8'h00, 8'h00, 16'h0078);
      ix(oad_pkg::M_INDEXED, 8'hF5, 8'h00, 8'h00, 16'h0105);
      ix(oad_pkg::M_INDEXED, 8'hEE, 8'h00, 8'h00, 16'hB005);
      ix(oad_pkg::M_REL9, 8'h10, 8'h00, 8'h00, 16'h1F01);
      aut(8'hA8, 16'h00F8, 16'h00F8, 2'h2);
      aut(8'h77, 16'h4000, 16'h4008, 2'h1);
      $display("test modes done");
   endtask : t_modes
   // One pointer slot; the new address lands one edge after it
   task ind(input logic [7:0] p, h, l, input logic [15:0] a);
      seq_i <= 32'h0000000E;
      seq_len_i <= 4'h1;
      go(oad_pkg::M_INDEXED, p, h, l);
      `CHK("ea_valid", 1'b0, ea_valid_o)
      tick;
      `CHK("kind", oad_pkg::K_PTR, bus_kind_o)
      `CHK("addr", a, bus_addr_o)
      `CHK("wide", 1'b1, bus_wide_o)
      idle;
      tick;
      `CHK("ea", {a[7:0], a[15:8]} ^ 16'h5A3C, ea_o)
      `CHK("ea_valid", 1'b1, ea_valid_o)
   endtask : ind
   task t_ind;
      ind(8'hE3, 8'h01, 8'h00, 16'h0108);
      ind(8'hF7, 8'h00, 8'h00, 16'h7105);
      $display("test indirect done");
   endtask : t_ind
   // Slots r f W O t V; the O slot outcome depends on alignment
   task t_full(input logic pg, input logic [15:0] f, input logic [2:0] b,
               input logic [2:0] ko);
      logic [2:0]  ek [6];
      logic [15:0] xa [6];
      ek = '{3'h2, 3'h0, 3'h3, ko, 3'h2, 3'h6};
      xa = '{16'h1234, 16'h0, 16'h1234, 16'h0, 16'h1234, 16'hFFF6};
      seq_i <= 32'h00BC2603;
      seq_len_i <= 4'h6;
      page2_i <= pg;
      fetch_addr_i <= f;
      obj_bytes_i <= b;
      cond_i <= 1'b1;
      vector_addr_i <= 16'hFFF7;
      irq_mark_i <= 8'h02;
      go(oad_pkg::M_FULL, 8'h00, 8'h12, 8'h34);
      `CHK("ea", 16'h1234, ea_o)
      for (int k = 0; k < 6; k++) begin
         tick;
         `CHK("kind", ek[k], bus_kind_o)
         `CHK("irq_ok", k == 1, irq_ok_o)
         `CHK("write", ek[k] == 3'h3, bus_write_o)
         if (ek[k] == 3'h0) `CHK("req", 1'b0, bus_req_o)
         else `CHK("wide", 6'b101100 >> k & 1'b1, bus_wide_o)
         if (xa[k] != 16'h0) `CHK("addr", xa[k], bus_addr_o)
         if (ek[k] == 3'h1) `CHK("align", 1'b0, bus_addr_o[0])
      end
      idle;
      $display("test sequence done");
   endtask : t_full
   task t_br(input logic tk);
      int n;
      n = tk ? 3 : 1;
      taken_i <= tk;
      fetch_addr_i <= 16'h3001;
      go(oad_pkg::M_REL8, 8'h00, 8'h00, 8'h80);
      if (tk) `CHK("ea", 16'h1F81, ea_o)
      for (int k = 0; k < n; k++) begin
         tick;
         `CHK("kind", oad_pkg::K_PROG, bus_kind_o)
         `CHK("addr", tk ? 16'h1F80 + 2 * k : 16'h3000, bus_addr_o)
         `CHK("busy", k < n - 1, busy_o)
         `CHK("irq_ok", 1'b0, irq_ok_o)
      end
      tick;
      `CHK("kind", oad_pkg::K_FREE, bus_kind_o)
      $display("test short branch done");
   endtask : t_br
   task t_lbr(input logic tk);
      logic [3:0] pat;
      pat = tk ? 4'b1110 : 4'b0010;
      taken_i <= tk;
      page2_i <= 1'b0;
      fetch_addr_i <= 16'h3000;
      obj_bytes_i <= 3'h4;
      go(oad_pkg::M_REL16, 8'h00, 8'h01, 8'h00);
      for (int k = 0; k < 3 + tk; k++) begin
         tick;
         `CHK("kind", {2'b00, pat[k]}, bus_kind_o)
      end
      idle;
      $display("test long branch done");
   endtask : t_lbr
   task t_trap;
      logic [7:0] tv [8];
      tv = '{8'h2F, 8'h30, 8'h39, 8'h3A, 8'h3F, 8'h40, 8'hFF, 8'h00};
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk_i);
         trap_num_i <= tv[k];
         #1;
         `CHK("trap_ok", 8'h66 >> k & 1'b1, trap_ok_o)
      end
      $display("test trap done");
   endtask : t_trap
   // Slots s U x: s U replayed once, then x with its condition false
   task t_loop;
      logic [2:0] ek [5];
      ek = '{3'h5, 3'h4, 3'h5, 3'h4, 3'h0};
      seq_i <= 32'h00000DA7;
      seq_len_i <= 4'h3;
      loop_end_i <= 3'h1;
      loop_cnt_i <= 8'h01;
      cond_i <= 1'b0;
      irq_mark_i <= 8'h02;
      go(oad_pkg::M_NONE, 8'h00, 8'h00, 8'h00);
      for (int k = 0; k < 5; k++) begin
         tick;
         `CHK("kind", ek[k], bus_kind_o)
         `CHK("irq_ok", k % 2 == 1, irq_ok_o)
         `CHK("wide", k % 2 == 1 && k < 4, bus_wide_o)
         `CHK("write", k % 2 == 0 && k < 4, bus_write_o)
         `CHK("req", k < 4, bus_req_o)
         if (k < 4) `CHK("addr", 16'h0100, bus_addr_o)
      end
      idle;
      $display("test loop done");
   endtask : t_loop
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_modes;
      t_ind;
      t_full(1'b0, 16'h3001, 3'h3, 3'h1);
      t_full(1'b1, 16'h3000, 3'h4, 3'h1);
      t_full(1'b0, 16'h3000, 3'h3, 3'h0);
      t_br(1'b1);
      t_br(1'b0);
      t_lbr(1'b1);
      t_lbr(1'b0);
      t_trap;
      t_loop;
      give_verdict;
   end
endmodule : oad_decode_test
`default_nettype wire
